// *** ssv_pkg.sv ***
package ssv_pkg;

  // Hold and expiry periods in their own units
  localparam int unsigned RESET_HOLD_PERIOD_MS = 200;
  localparam int unsigned WATCHDOG_EXPIRY_PERIOD_MS = 1600;
  localparam int unsigned CLK_FREQ_HZ = 125_000_000;
  localparam int unsigned MS_PER_S = 1000;

  // Cycle counts derived from the clock rate
  localparam longint unsigned RESET_HOLD_CYCLES =
    longint'(RESET_HOLD_PERIOD_MS) * CLK_FREQ_HZ / MS_PER_S;
  localparam longint unsigned WATCHDOG_EXPIRY_CYCLES =
    longint'(WATCHDOG_EXPIRY_PERIOD_MS) * CLK_FREQ_HZ / MS_PER_S;

  // Counter width, enough for the longest default count
  localparam int unsigned CNT_W = 32;

  // Reset line states
  localparam logic RST_ACTIVE_N = 1'b0;
  localparam logic RST_IDLE_N = 1'b1;

  // Supervisor states, Gray coded along the path
  typedef enum logic [1:0] {
    SSV_HOLD = 2'b00,
    SSV_STRETCH = 2'b01,
    SSV_RUN = 2'b11,
    SSV_PULSE = 2'b10
  } ssv_state_t;

  // Synchronised external causes
  typedef struct packed {
    logic supply_low;
    logic low_line;
    logic manual_reset_request_n;
    logic watchdog_toggle_in;
  } ssv_inputs_t;

  // Synchroniser reset value: supply low, low line, no request, line low
  localparam ssv_inputs_t SSV_SYNC_RESET = '{
    supply_low: 1'b1,
    low_line: 1'b1,
    manual_reset_request_n: 1'b1,
    watchdog_toggle_in: 1'b0
  };

endpackage : ssv_pkg

// *** ssv_supervisor.sv ***
`timescale 1ns/100ps
module ssv_supervisor #(
  parameter longint unsigned HOLD_CYCLES = ssv_pkg::RESET_HOLD_CYCLES,
  parameter longint unsigned EXPIRY_CYCLES = ssv_pkg::WATCHDOG_EXPIRY_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Causes from pins
  input wire logic i_supply_low,
  input wire logic i_low_line,
  input wire logic i_manual_reset_request_n,
  input wire logic i_watchdog_toggle_in,
  // Reset and warning outputs
  output logic o_reset_n,
  output logic o_reset,
  output logic o_low_line_warning_n
);
  import ssv_pkg::*;

  // Build-time period checks, refused at elaboration
  localparam longint unsigned CNT_LIMIT = 64'h1 << CNT_W;
  if (HOLD_CYCLES < 1) begin : g_hold_short
    $error("hold count must be at least one cycle");
  end
  if (HOLD_CYCLES > CNT_LIMIT) begin : g_hold_long
    $error("hold count does not fit the counter");
  end
  if (EXPIRY_CYCLES < 1) begin : g_exp_short
    $error("expiry count must be at least one cycle");
  end
  if (EXPIRY_CYCLES > CNT_LIMIT) begin : g_exp_long
    $error("expiry count does not fit the counter");
  end

  // Last counter values, fixed per build
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] EXP_LAST = CNT_W'(EXPIRY_CYCLES - 1);

  // Reset is asserted in every state but the run state
  function automatic logic f_reset_on(input ssv_state_t st);
    return (st != SSV_RUN);
  endfunction

  // Counter has reached its last cycle
  function automatic logic f_at_last(input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] last);
    return (cnt == last);
  endfunction

  // One step of a period counter, never steps past the top by the checks
  function automatic logic [CNT_W-1:0] f_step(input logic [CNT_W-1:0] cnt);
    return cnt + 1'b1;
  endfunction

  // Pin samples, synchroniser stages and edge memory
  ssv_inputs_t pins_in;
  ssv_inputs_t meta_q;
  ssv_inputs_t sync_q;
  logic wd_prev_q;

  // Supervisor state, period counters and warning flop
  ssv_state_t state_q;
  ssv_state_t state_d;
  logic [CNT_W-1:0] hold_cnt_q;
  logic [CNT_W-1:0] hold_cnt_d;
  logic [CNT_W-1:0] wd_cnt_q;
  logic [CNT_W-1:0] wd_cnt_d;
  logic llo_q;

  // Gather the asynchronous causes into one word
  assign pins_in = {i_supply_low, i_low_line, i_manual_reset_request_n,
    i_watchdog_toggle_in};

  // First synchroniser stage
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= SSV_SYNC_RESET;
    end else begin
      meta_q <= pins_in;
    end
  end

  // Second stage, the only reader of the first
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_q <= SSV_SYNC_RESET;
    end else begin
      sync_q <= meta_q;
    end
  end

  // Last synchronised watchdog level, for edge detection
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wd_prev_q <= SSV_SYNC_RESET.watchdog_toggle_in;
    end else begin
      wd_prev_q <= sync_q.watchdog_toggle_in;
    end
  end

  // Reset causes
  wire level_cause = sync_q.supply_low | ~sync_q.manual_reset_request_n;
  wire wd_edge = sync_q.watchdog_toggle_in ^ wd_prev_q;

  // Counter end points
  wire hold_done = f_at_last(hold_cnt_q, HOLD_LAST);
  wire wd_expired = f_at_last(wd_cnt_q, EXP_LAST) & ~wd_edge;

  // Reset state now and next
  wire in_reset = f_reset_on(state_q);
  wire reset_on_d = f_reset_on(state_d);

  // Next state and hold counter
  always_comb begin
    state_d = state_q;
    hold_cnt_d = hold_cnt_q;
    case (state_q)
      SSV_HOLD: begin
        hold_cnt_d = '0;
        if (!level_cause) begin
          state_d = SSV_STRETCH;
        end
      end
      SSV_STRETCH, SSV_PULSE: begin
        if (level_cause) begin
          state_d = SSV_HOLD;
          hold_cnt_d = '0;
        end else if (hold_done) begin
          state_d = SSV_RUN;
          hold_cnt_d = '0;
        end else begin
          hold_cnt_d = f_step(hold_cnt_q);
        end
      end
      SSV_RUN: begin
        hold_cnt_d = '0;
        if (level_cause) begin
          state_d = SSV_HOLD;
        end else if (wd_expired) begin
          state_d = SSV_PULSE;
        end
      end
      default: begin
        state_d = SSV_HOLD;
        hold_cnt_d = '0;
      end
    endcase
  end

  // Watchdog counter: held clear in reset, restarted by any edge
  always_comb begin
    if (in_reset) begin
      wd_cnt_d = '0;
    end else if (wd_edge) begin
      wd_cnt_d = '0;
    end else if (wd_expired) begin
      wd_cnt_d = '0;
    end else begin
      wd_cnt_d = f_step(wd_cnt_q);
    end
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= SSV_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // Period counter registers
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_cnt_q <= '0;
      wd_cnt_q <= '0;
    end else begin
      hold_cnt_q <= hold_cnt_d;
      wd_cnt_q <= wd_cnt_d;
    end
  end

  // Low-line warning flop, shown low during reset too
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      llo_q <= RST_ACTIVE_N;
    end else begin
      llo_q <= ~sync_q.low_line;
    end
  end

  // Both polarities from the same next-state decode
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reset_n <= RST_ACTIVE_N;
      o_reset <= ~RST_ACTIVE_N;
    end else begin
      o_reset_n <= reset_on_d ? RST_ACTIVE_N : RST_IDLE_N;
      o_reset <= reset_on_d;
    end
  end

  // Warning output straight from its flop
  assign o_low_line_warning_n = llo_q;

endmodule // ssv_supervisor

// *** ssv_supervisor_sva.sv ***
`timescale 1ns/100ps
module ssv_supervisor_sva #(
  parameter longint unsigned HOLD_CYCLES = 20, EXPIRY_CYCLES = 100
) (
  // Watched ports
  input wire logic i_core_clk, i_reset_n, i_supply_low, i_low_line,
  input wire logic i_manual_reset_request_n, i_watchdog_toggle_in,
  input wire logic o_reset_n, o_reset, o_low_line_warning_n
);
  logic [31:0] idle_q;
  // Cycles since the last kick while reset is released
  always_ff @(posedge i_core_clk) begin
    idle_q <= (~o_reset_n | $changed(i_watchdog_toggle_in)) ? '0 : idle_q+1;
  end
  logic [31:0] low_q;
  // Cycles reset has stayed low since release of the core reset
  always_ff @(posedge i_core_clk) begin
    low_q <= (!i_reset_n || o_reset_n) ? '0 : low_q + 1;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  chk_supply_hold: assert property (i_supply_low[*4] |=> !o_reset_n)
    else $error("supply");
  chk_manual_hold: assert property (
    !i_manual_reset_request_n[*4] |=> !o_reset_n) else $error("manual");
  chk_pulse_len: assert property ($fell(o_reset_n) |=> !o_reset_n[*8])
    else $error("pulse");
  chk_supply_tail: assert property (
    $fell(i_supply_low) |=> !o_reset_n[*8]) else $error("supply tail");
  chk_manual_tail: assert property (
    $rose(i_manual_reset_request_n) |=> !o_reset_n[*8]) else $error("tail");
  chk_out_inverse: assert property (o_reset != o_reset_n)
    else $error("inverse");
  chk_warn_low: assert property (
    i_low_line[*4] |=> !o_low_line_warning_n) else $error("warn low");
  chk_warn_high: assert property (
    !i_low_line[*4] |=> o_low_line_warning_n) else $error("warn high");
  chk_wd_expiry: assert property (
    o_reset_n |-> idle_q < EXPIRY_CYCLES + 8) else $error("expiry");
  chk_hold_len: assert property ($rose(o_reset_n) |-> low_q >= HOLD_CYCLES)
    else $error("hold short");
  // Main scenarios
  cover property ($fell(o_reset_n));
  cover property ($rose(o_reset_n));
  cover property ($rose(o_low_line_warning_n));
endmodule // ssv_supervisor_sva
bind ssv_supervisor ssv_supervisor_sva #(.HOLD_CYCLES(HOLD_CYCLES),
  .EXPIRY_CYCLES(EXPIRY_CYCLES)) u_ssv_supervisor_sva (.*);

// *** ssv_host_model.sv ***
`timescale 1ns/100ps
module ssv_host_model (
  // Clock, kick enable, reset from the supervisor
  input wire logic i_core_clk,
  input wire logic i_kick_en,
  input wire logic i_cpu_reset_n,
  // Watchdog line
  output logic o_watchdog_toggle_in
);
  logic [5:0] cnt_q;
  wire logic tick = i_kick_en && cnt_q == 6'h3b;
  // Toggle every 60 cycles while kicks are enabled out of reset, line low in reset
  always_ff @(posedge i_core_clk) begin
    cnt_q <= (!i_cpu_reset_n || cnt_q == 6'h3b) ? '0 : cnt_q + 6'h01;
    if (!i_cpu_reset_n) o_watchdog_toggle_in <= 1'b0;
    else o_watchdog_toggle_in <= o_watchdog_toggle_in ^ tick;
  end
endmodule // ssv_host_model

// *** ssv_supervisor_bench.sv ***
`timescale 1ns/100ps
module ssv_supervisor_bench;
  logic clk = 0, rst_n = 0, sup = 1, ll = 1, mr_n = 1, kick = 1;
  logic wd, rn, r, lln;
  int error_cnt = 0, checks = 0, n;
  // Short counts, host model on the watchdog line
  ssv_supervisor #(.HOLD_CYCLES(20), .EXPIRY_CYCLES(100)) u_ssv_supervisor (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_supply_low(sup),
    .i_low_line(ll), .i_manual_reset_request_n(mr_n),
    .i_watchdog_toggle_in(wd), .o_reset_n(rn), .o_reset(r),
    .o_low_line_warning_n(lln));
  ssv_host_model u_ssv_host_model (.i_core_clk(clk), .i_kick_en(kick),
    .i_cpu_reset_n(rn), .o_watchdog_toggle_in(wd));
  // 125 MHz clock
  initial forever #4 clk = ~clk;
  // Compare and count
  task automatic chk(input logic s, input logic e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %0t got %b", $time, s);
    end
  endtask
  // Cycles until reset reaches a level
  task automatic wfor(input logic v);
    for (n = 0; rn !== v && n < 300; n++) @(posedge clk);
    chk(r, !v);
  endtask
  // Supply and low line low at power-up, then cleared
  task automatic t_supply;
    repeat (30) @(posedge clk);
    chk(rn, 1'b0);
    chk(lln, 1'b0);
    sup <= 1'b0;
    ll <= 1'b0;
    wfor(1'b1);
    chk(n > 19 && n < 27, 1'b1);
    chk(lln, 1'b1);
  endtask
  // Manual request, then two expiries without kicks
  task automatic t_watchdog;
    mr_n <= 1'b0;
    kick <= 1'b0;
    repeat (30) @(posedge clk);
    chk(rn, 1'b0);
    mr_n <= 1'b1;
    wfor(1'b1);
    chk(n > 19 && n < 27, 1'b1);
    repeat (2) begin
      wfor(1'b0);
      chk(n > 97 && n < 109, 1'b1);
      wfor(1'b1);
      chk(n > 18 && n < 27, 1'b1);
    end
  endtask
  // Kicks 60 cycles apart on both edges
  task automatic t_kick;
    kick <= 1'b1;
    repeat (400) begin
      @(posedge clk);
      chk(rn, 1'b1);
    end
  endtask
  task automatic tally_and_finish;
    $display("Errors %0d in %0d checks", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Three reset cycles, then the scenarios
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_supply;
    t_watchdog;
    t_kick;
    tally_and_finish;
  end
  // Hang limit over two and a half times the run of about 6000 ns
  initial begin
    #16000;
    error_cnt++;
    tally_and_finish;
  end
endmodule // ssv_supervisor_bench
